// file: hdl/pom_pin_output_source_mux.sv
/*
 * Output source multiplexer and driver control for general-purpose pin 4.
 * Assumes all status inputs are synchronous to ref_clk_i and a classic
 * Wishbone master; the pin itself is resolved outside from data and enable.
 */
`default_nettype none
module pom_pin_output_source_mux
    import pom_pkg::*;
#(
    parameter int unsigned NUM_RX = POM_NUM_RX
)
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [POM_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [POM_DATA_W-1:0] wb_dat_i,
    output logic [POM_DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire pom_rx_s [NUM_RX-1:0] rx_status_i,
    input wire pom_tx_s tx_status_i,
    output logic pin4_data_o,
    output logic pin4_oe_n_o
);

    logic [POM_CTRL_W-1:0] pin4_output_control_r;
    logic ack_r;
    logic [POM_DATA_W-1:0] rdata_r;
    logic pin_data_r;
    logic pin_oe_n_r;
    logic mux_nxt;
    logic pin4_drive_enable;
    logic pin4_local_value;
    pom_code_t pin4_output_source;
    pom_code_t pin4_output_select;
    logic lock_any;
    logic pass_all_en;
    logic pass_all_sel;
    logic pass_any_sel;
    logic bus_req;

    assign pin4_drive_enable = pin4_output_control_r[POM_EN_BIT];
    assign pin4_local_value = pin4_output_control_r[POM_VAL_BIT];
    assign pin4_output_source = pin4_output_control_r[POM_SRC_MSB:POM_SRC_LSB];
    assign pin4_output_select = pin4_output_control_r[POM_SEL_MSB:POM_SEL_LSB];
    // A new request is taken only while no ack is out, so each ack lasts one cycle.
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;

    // Port-wide aggregates; disabled ports are left out of lock_any and pass_all_en, while the tx_selected terms ignore enabled.
    always_comb
    begin
        lock_any = 1'b0;
        pass_all_en = 1'b1;
        pass_all_sel = 1'b1;
        pass_any_sel = 1'b0;
        for (int i = 0; i < NUM_RX; i++)
        begin
            if (rx_status_i[i].enabled)
            begin
                lock_any = lock_any | rx_status_i[i].lock;
                pass_all_en = pass_all_en & rx_status_i[i].pass;
            end
            if (rx_status_i[i].tx_selected)
            begin
                pass_all_sel = pass_all_sel & rx_status_i[i].pass;
                pass_any_sel = pass_any_sel | rx_status_i[i].pass;
            end
        end
    end

    // Pick one signal of one receive port by select code.
    function automatic logic rx_pick(input pom_rx_s st, input pom_code_t sel);
        logic r;
        r = 1'b0;
        case (sel)
            POM_RX_LOCK: r = st.lock;
            POM_RX_PASS: r = st.pass;
            POM_RX_FV: r = st.frame_valid;
            POM_RX_LV: r = st.line_valid;
            default: r = st.remote_gpio[sel[1:0]];
        endcase
        return r;
    endfunction : rx_pick

    always_comb
    begin
        mux_nxt = 1'b0;
        if (pin4_output_source <= POM_SRC_RX3)
        begin
            // Ports beyond NUM_RX are absent and read as low.
            if (32'(pin4_output_source) < NUM_RX)
            begin
                mux_nxt = rx_pick(rx_status_i[pin4_output_source[1:0]],
                    pin4_output_select);
            end
        end
        else if (pin4_output_source == POM_SRC_DEV)
        begin
            case (pin4_output_select)
                POM_DEV_VAL: mux_nxt = pin4_local_value;
                POM_DEV_LOCK_OR: mux_nxt = lock_any;
                POM_DEV_PASS_A: mux_nxt = pass_all_en;
                POM_DEV_PASS_B: mux_nxt = pass_all_en;
                POM_DEV_FSYNC: mux_nxt = tx_status_i.frame_sync_pulse;
                default: mux_nxt = 1'b0;
            endcase
        end
        else if (pin4_output_source == POM_SRC_TX0)
        begin
            case (pin4_output_select)
                POM_TX_PASS_AND: mux_nxt = pass_all_sel;
                POM_TX_PASS_OR: mux_nxt = pass_any_sel;
                POM_TX_FV: mux_nxt = tx_status_i.frame_valid;
                POM_TX_LV: mux_nxt = tx_status_i.line_valid;
                POM_TX_SYNCED: mux_nxt = tx_status_i.synced;
                POM_TX_IRQ: mux_nxt = tx_status_i.irq;
                default: mux_nxt = 1'b0;
            endcase
        end
    end

    // Control register; only byte lane 0 carries its bits.
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            pin4_output_control_r <= POM_CTRL_RST;
        end
        else if (bus_req && wb_we_i && wb_adr_i == POM_CTRL_ADDR && wb_sel_i[0])
        begin
            pin4_output_control_r <= wb_dat_i[POM_CTRL_W-1:0];
        end
    end

    // Every access, mapped or not, is acked one cycle after it is seen.
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            ack_r <= 1'b0;
            rdata_r <= POM_UNMAPPED_DATA;
        end
        else
        begin
            ack_r <= bus_req;
            rdata_r <= POM_UNMAPPED_DATA;
            if (bus_req && !wb_we_i)
            begin
                if (wb_adr_i == POM_CTRL_ADDR)
                begin
                    rdata_r <= {{(POM_DATA_W-POM_CTRL_W){1'b0}}, pin4_output_control_r};
                end
                else if (wb_adr_i == POM_STATUS_ADDR)
                begin
                    rdata_r <= {{(POM_DATA_W-2){1'b0}}, !pin_oe_n_r, pin_data_r};
                end
            end
        end
    end

    // The pin stage is registered so the pad sees no glitch from the mux.
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            pin_data_r <= 1'b0;
            pin_oe_n_r <= 1'b1;
        end
        else
        begin
            pin_oe_n_r <= !pin4_drive_enable;
            pin_data_r <= pin4_drive_enable ? mux_nxt : 1'b0;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;
    assign pin4_data_o = pin_data_r;
    assign pin4_oe_n_o = pin_oe_n_r;

endmodule : pom_pin_output_source_mux
`default_nettype wire

// file: hdl/pom_pkg.sv
/*
 * Package for the pin output source multiplexer: register map, field layout,
 * source and select codes, and the carrier structs for port status.
 * Assumes a classic Wishbone slave with 32-bit data and byte addressing.
 */
`default_nettype none
package pom_pkg;
    localparam int unsigned POM_ADDR_W = 8;
    localparam int unsigned POM_DATA_W = 32;
    localparam int unsigned POM_NUM_RX = 4;
    localparam logic [POM_ADDR_W-1:0] POM_CTRL_ADDR = 8'h14;
    localparam logic [POM_ADDR_W-1:0] POM_STATUS_ADDR = 8'h18;
    localparam int unsigned POM_CTRL_W = 8;
    localparam int unsigned POM_EN_BIT = 0;
    localparam int unsigned POM_VAL_BIT = 1;
    localparam int unsigned POM_SRC_LSB = 2;
    localparam int unsigned POM_SRC_MSB = 4;
    localparam int unsigned POM_SEL_LSB = 5;
    localparam int unsigned POM_SEL_MSB = 7;
    localparam logic [POM_CTRL_W-1:0] POM_CTRL_RST = 8'h00;
    localparam logic [POM_DATA_W-1:0] POM_UNMAPPED_DATA = 32'h00000000;

    typedef logic [2:0] pom_code_t;

    localparam pom_code_t POM_SRC_RX3 = 3'h3;
    localparam pom_code_t POM_SRC_DEV = 3'h4;
    localparam pom_code_t POM_SRC_TX0 = 3'h6;

    localparam pom_code_t POM_RX_LOCK = 3'h4;
    localparam pom_code_t POM_RX_PASS = 3'h5;
    localparam pom_code_t POM_RX_FV = 3'h6;
    localparam pom_code_t POM_RX_LV = 3'h7;

    localparam pom_code_t POM_DEV_VAL = 3'h0;
    localparam pom_code_t POM_DEV_LOCK_OR = 3'h1;
    localparam pom_code_t POM_DEV_PASS_A = 3'h2;
    localparam pom_code_t POM_DEV_PASS_B = 3'h3;
    localparam pom_code_t POM_DEV_FSYNC = 3'h4;

    localparam pom_code_t POM_TX_PASS_AND = 3'h0;
    localparam pom_code_t POM_TX_PASS_OR = 3'h1;
    localparam pom_code_t POM_TX_FV = 3'h2;
    localparam pom_code_t POM_TX_LV = 3'h3;
    localparam pom_code_t POM_TX_SYNCED = 3'h4;
    localparam pom_code_t POM_TX_IRQ = 3'h5;

    // Status of one receive port, as produced by its link logic.
    typedef struct packed {
        logic [3:0] remote_gpio;
        logic lock;
        logic pass;
        logic frame_valid;
        logic line_valid;
        logic enabled;
        logic tx_selected;
    } pom_rx_s;

    // Status of the transmit port and device-wide signals.
    typedef struct packed {
        logic frame_valid;
        logic line_valid;
        logic synced;
        logic irq;
        logic frame_sync_pulse;
    } pom_tx_s;
endpackage : pom_pkg
`default_nettype wire

// file: verification/pom_mux_asserts.sv
/* Checker for the pin output mux: bus answer, driver enable and source selection.
   Bound to the mux; assumes one classic Wishbone master driving its bus. */
`default_nettype none
module pom_mux_asserts
    import pom_pkg::*;
#(
    parameter int unsigned NUM_RX = POM_NUM_RX
)
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [POM_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [POM_DATA_W-1:0] wb_dat_i,
    input wire logic [POM_DATA_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire pom_rx_s [NUM_RX-1:0] rx_status_i,
    input wire pom_tx_s tx_status_i,
    input wire logic pin4_data_o,
    input wire logic pin4_oe_n_o
);
    logic [7:0] ctl_r;
    pom_rx_s [NUM_RX-1:0] rx_q;
    pom_tx_s tx_q;
    logic en;
    logic [2:0] s;
    logic [2:0] k;
    assign en = ctl_r[0];
    assign s = ctl_r[4:2];
    assign k = ctl_r[7:5];
    // The shadow lags the register by one cycle, the same lag the registered pin adds.
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            ctl_r <= POM_CTRL_RST;
        else if (wb_ack_o && wb_we_i && wb_adr_i == POM_CTRL_ADDR && wb_sel_i[0])
            ctl_r <= wb_dat_i[7:0];
    end
    always_ff @(posedge ref_clk_i)
    begin
        rx_q <= rx_status_i;
        tx_q <= tx_status_i;
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ans;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_pulse: assert property (s_req |=> s_ans)
        else $error("ack is not a single pulse after the request");
    a_rd_ctrl: assert property (wb_ack_o && !wb_we_i && wb_adr_i == POM_CTRL_ADDR |->
        wb_dat_o == {24'h000000, ctl_r}) else $error("control read back wrong");
    a_oe_enable: assert property (pin4_oe_n_o != en)
        else $error("output enable does not follow the enable bit");
    a_off_low: assert property (pin4_oe_n_o |-> !pin4_data_o)
        else $error("pin not low while disabled");
    a_local_val: assert property (en && s == 3'h4 && k == 3'h0 |-> pin4_data_o == ctl_r[1])
        else $error("local value not on pin");
    a_rx_gpio: assert property (en && !s[2] && !k[2] |->
        pin4_data_o == rx_q[s[1:0]].remote_gpio[k[1:0]]) else $error("remote input wrong");
    a_rx_sig: assert property (en && !s[2] && k[2] |-> pin4_data_o == rx_q[s[1:0]][9-k])
        else $error("receive port signal wrong");
    a_dev_fsync: assert property (en && s == 3'h4 && k == 3'h4 |->
        pin4_data_o == tx_q.frame_sync_pulse) else $error("frame sync not on pin");
    a_tx_sig: assert property (en && s == 3'h6 && k inside {[2:5]} |->
        pin4_data_o == tx_q[6-k]) else $error("transmit port signal wrong");
    a_rsvd_low: assert property (en && (s == 3'h5 || s == 3'h7 || (s == 3'h4 && k > 3'h4) ||
        (s == 3'h6 && k > 3'h5)) |-> !pin4_data_o) else $error("reserved code not low");
endmodule : pom_mux_asserts
bind pom_pin_output_source_mux pom_mux_asserts #(.NUM_RX(NUM_RX)) i_chk (.ref_clk_i, .sys_rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .rx_status_i, .tx_status_i, .pin4_data_o, .pin4_oe_n_o);
`default_nettype wire

// file: verification/pom_tb.sv
/* Testbench for the pin output mux: sweeps every control value over two status
   patterns against a reference, then bus refusals. Expects the checker bound. */
`default_nettype none
module tb
    import pom_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, ack, oen, pin;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, dato, q;
    pom_rx_s [3:0] rx = '0;
    pom_tx_s tx = '0;
    int error_cnt = 0, cmp_count = 0;
    always #4 clk = ~clk;
    pom_pin_output_source_mux i_dut (.ref_clk_i(clk), .sys_rst_i(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dato), .wb_ack_o(ack), .rx_status_i(rx), .tx_status_i(tx),
        .pin4_data_o(pin), .pin4_oe_n_o(oen));
    task automatic summarize();
        $display("compares %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask : chk
    // Ack and read data are sampled at the rising edge that ends the request.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] r);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, s};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'h1 && n < 20);
        if (ack !== 1'h1)
        begin
            error_cnt++;
            summarize();
        end
        r = dato;
        {cyc, stb, we} <= 3'h0;
    endtask : wb
    function automatic logic ef(input logic [7:0] c);
        logic lor, pand, tand, tor;
        pom_rx_s r;
        {lor, pand, tand, tor} = 4'h6;
        for (int i = 0; i < 4; i++)
        begin
            lor |= rx[i].enabled & rx[i].lock;
            pand &= ~rx[i].enabled | rx[i].pass;
            tand &= ~rx[i].tx_selected | rx[i].pass;
            tor |= rx[i].tx_selected & rx[i].pass;
        end
        r = rx[c[3:2]];
        if (!c[0])
            return 1'h0;
        if (!c[4])
            return c[7] ? r[9-c[7:5]] : r.remote_gpio[c[6:5]];
        case ({c[4:2], c[7:5]})
            6'h20: return c[1];
            6'h21: return lor;
            6'h22, 6'h23: return pand;
            6'h24: return tx.frame_sync_pulse;
            6'h30: return tand;
            6'h31: return tor;
            6'h32, 6'h33, 6'h34, 6'h35: return tx[6-c[7:5]];
            default: return 1'h0;
        endcase
    endfunction : ef
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        wb(1'h0, POM_CTRL_ADDR, 32'h0, 4'hF, q);
        chk(q, 32'h0);
        for (int p = 0; p < 2; p++)
        begin
            rx <= p ? ~40'hA53C96E10F : 40'hA53C96E10F;
            tx <= p ? 5'h0A : 5'h15;
            for (int c = 0; c < 256; c++)
            begin
                wb(1'h1, POM_CTRL_ADDR, c, 4'h1, q);
                wb(1'h0, POM_CTRL_ADDR, 32'h0, 4'h1, q);
                chk(q, c);
                @(negedge clk);
                chk(pin, ef(c[7:0]));
                chk(oen, !c[0]);
            end
        end
        wb(1'h1, POM_CTRL_ADDR, 32'h13, 4'h1, q);
        wb(1'h0, POM_STATUS_ADDR, 32'h0, 4'h1, q);
        chk(q, 32'h3);
        wb(1'h1, 8'h20, 32'hFF, 4'hF, q);
        wb(1'h0, 8'h20, 32'h0, 4'hF, q);
        chk(q, POM_UNMAPPED_DATA);
        wb(1'h1, POM_CTRL_ADDR, 32'h0, 4'h0, q);
        wb(1'h0, POM_CTRL_ADDR, 32'h0, 4'h1, q);
        chk(q, 32'h13);
        summarize();
    end
endmodule : tb
`default_nettype wire
